//--- halt_wake_regs.vh
/*
 * constants for the halt wake status flag block: status bit positions,
 * instruction operands and reset values.
 * assumes the core decodes instructions and pulses the matching strobes.
 */
// How it works
// - three four-bit status registers, core readable
// - zero indicator set one cycle after accumulator zero
// - carry takes alu carry, or memory load
// - pin-2 gated count end sets flag 12
// - pin-1 gated count end sets flag 11
// - gate-wake instruction again clears flags 11, 12
// - arith status: carry, zero, gate12, gate11
// - port d change sets its wake flag
// - port c change sets its wake flag
// - summary flag is or of wake flags 4, 5, 6, 7, 9, 10
// - halt refused while any wake flag set
// - set/reset flag op 2h drives backup indicator
// - status 2: port d, summary, port c, backup
// - int edge request with enable 2 sets flag 4
// - clearing request 2 or enable 2 clears flag 4
// - timer underflow with enable 1 sets flag 5
// - clearing request 1 or enable 1 clears flag 5
// - prescaler overflow with enable 3 sets flag 7
// - status 3: flag 7, stage 15, flag 5, flag 4
`ifndef HALT_WAKE_REGS_VH
`define HALT_WAKE_REGS_VH

`define NIBBLE_W 4
`define NIBBLE_ZERO 4'h0
`define BACKUP_OPERAND 4'h2

`define ST1_CARRY 3
`define ST1_ZERO 2
`define ST1_GATE12 1
`define ST1_GATE11 0

`define ST2_PORT_D 3
`define ST2_SUMMARY 2
`define ST2_PORT_C 1
`define ST2_BACKUP 0

`define ST3_WAKE7 3
`define ST3_STAGE15 2
`define ST3_WAKE5 1
`define ST3_WAKE4 0

`define HR_TIMER 0
`define HR_INT 1
`define HR_PRESC 2
`define HR_N 3

`define GW_FIRST 0
`define GW_SECOND 1
`define PW_PORT_C 0
`define PW_PORT_D 1

`define SYNC_ARM_W 3

`endif

//--- wake_sticky.v
/*
 * one sticky wake flag: set by a source event under its enable, cleared
 * by the instruction that clears its request or enable.
 * assumes event and clear are single-cycle strobes on sys_clk.
 */
`timescale 1ns/10ps
`include "halt_wake_regs.vh"
module wake_sticky (
    input wire sys_clk,
    input wire nrst,
    input wire enable,
    input wire set_evt,
    input wire clr_evt,
    output reg flag_q
);
    // set wins over a clear in the same cycle so no event is lost
    always @(posedge sys_clk) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (set_evt && enable) begin
            flag_q <= 1'b1;
        end else if (clr_evt || !enable) begin
            flag_q <= 1'b0;
        end
    end
endmodule

//--- halt_wake_status_flags.v
/*
 * status flag logic for halt release sources, carry/zero and backup mode.
 * assumes the core presents one-cycle instruction strobes with operands
 * on sys_clk; pins are asynchronous and synchronised here.
 */
`timescale 1ns/10ps
`include "halt_wake_regs.vh"
module halt_wake_status_flags (
    input wire sys_clk,
    input wire nrst,
    input wire [3:0] accumulator,
    input wire alu_carry_we,
    input wire alu_carry,
    input wire load_carry_op,
    input wire [3:0] load_carry_data,
    input wire gate_wake_instruction,
    input wire [1:0] gate_wake_operand,
    input wire gate_by_first_pin,
    input wire gate_by_second_pin,
    input wire first_counter_input_pin,
    input wire second_counter_input_pin,
    input wire port_wake_instruction,
    input wire [1:0] port_wake_operand,
    input wire [3:0] port_c,
    input wire [3:0] port_d,
    input wire set_flag_op,
    input wire reset_flag_op,
    input wire [3:0] flag_operand,
    input wire int_pin,
    input wire int_rising,
    input wire first_timer_underflow,
    input wire prescaler_overflow,
    input wire prescaler_stage_15,
    input wire request_clear_op,
    input wire [2:0] request_clear_mask,
    input wire enable_set_op,
    input wire [2:0] enable_set_value,
    input wire halt_req,
    input wire wake_6_in,
    input wire wake_9_in,
    input wire wake_10_in,
    output reg [3:0] arith_and_gate_wake_status,
    output reg [3:0] port_and_backup_wake_status,
    output reg [3:0] wake_status_three,
    output wire halt_grant,
    output wire backup_mode
);
    reg carry_q;
    reg zero_q;
    reg backup_q;
    reg gate11_q;
    reg gate12_q;
    reg pc_q;
    reg pd_q;
    reg [1:0] gate_en_q;
    reg [1:0] port_en_q;
    reg [2:0] hr_en_q;
    reg [2:0] hr_req_q;
    reg [1:0] cx1_s;
    reg [1:0] cx2_s;
    reg [1:0] int_s;
    reg [3:0] pc_s0;
    reg [3:0] pc_s1;
    reg [3:0] pc_s2;
    reg [3:0] pd_s0;
    reg [3:0] pd_s1;
    reg [3:0] pd_s2;
    reg cx1_d;
    reg cx2_d;
    reg int_d;
    reg ph_s0;
    reg ph_s1;
    reg [`SYNC_ARM_W-1:0] arm_q;
    wire armed;
    wire w4;
    wire w5;
    wire w7;
    wire summary;
    wire [2:0] hr_evt;
    wire [2:0] hr_clr;
    wire int_edge;
    wire gate11_end;
    wire gate12_end;
    wire pc_change;
    wire pd_change;
    wire any_flag;

    // one compare shared by the set and reset flag decodes
    function is_backup_op;
        input [3:0] operand;
        begin
            is_backup_op = (operand == `BACKUP_OPERAND);
        end
    endfunction

    // two-flop synchronisers; first stage feeds only the second
    always @(posedge sys_clk) begin
        if (!nrst) begin
            cx1_s <= 2'h0;
            cx2_s <= 2'h0;
            int_s <= 2'h0;
            pc_s0 <= 4'h0;
            pc_s1 <= 4'h0;
            pd_s0 <= 4'h0;
            pd_s1 <= 4'h0;
            ph_s0 <= 1'b0;
            ph_s1 <= 1'b0;
        end else begin
            cx1_s <= {cx1_s[0], first_counter_input_pin};
            cx2_s <= {cx2_s[0], second_counter_input_pin};
            int_s <= {int_s[0], int_pin};
            pc_s0 <= port_c;
            pc_s1 <= pc_s0;
            pd_s0 <= port_d;
            pd_s1 <= pd_s0;
            ph_s0 <= prescaler_stage_15;
            ph_s1 <= ph_s0;
        end
    end

    // delayed copies of the pin syncs for edge detection
    always @(posedge sys_clk) begin
        if (!nrst) begin
            cx1_d <= 1'b0;
            cx2_d <= 1'b0;
            int_d <= 1'b0;
        end else begin
            cx1_d <= cx1_s[1];
            cx2_d <= cx2_s[1];
            int_d <= int_s[1];
        end
    end

    // delayed copies of the port syncs for change detection
    always @(posedge sys_clk) begin
        if (!nrst) begin
            pc_s2 <= 4'h0;
            pd_s2 <= 4'h0;
        end else begin
            pc_s2 <= pc_s1;
            pd_s2 <= pd_s1;
        end
    end

    // sync stages start at zero, so a pin idling high would look like
    // an edge or change; hold detection off until both sides are real
    always @(posedge sys_clk) begin
        if (!nrst) begin
            arm_q <= {`SYNC_ARM_W{1'b0}};
        end else begin
            arm_q <= {arm_q[`SYNC_ARM_W-2:0], 1'b1};
        end
    end
    assign armed = arm_q[`SYNC_ARM_W-1];

    // edge polarity is a build-time strap, so a plain input suffices
    assign int_edge = armed & (int_rising ? (int_s[1] & ~int_d) :
                               (~int_s[1] & int_d));

    // end of the control pulse is its falling edge
    assign gate11_end = cx1_d & ~cx1_s[1];
    assign gate12_end = cx2_d & ~cx2_s[1];
    // any bit of the nibble moving counts as a change
    assign pc_change = armed & (pc_s1 != pc_s2);
    assign pd_change = armed & (pd_s1 != pd_s2);

    // a memory load beats an alu write in the same cycle
    always @(posedge sys_clk) begin
        if (!nrst) begin
            carry_q <= 1'b0;
        end else if (load_carry_op) begin
            carry_q <= load_carry_data[`ST1_CARRY];
        end else if (alu_carry_we) begin
            carry_q <= alu_carry;
        end
    end

    // registered, so it trails the accumulator by one cycle
    always @(posedge sys_clk) begin
        if (!nrst) begin
            zero_q <= 1'b1;
        end else begin
            zero_q <= (accumulator == `NIBBLE_ZERO);
        end
    end

    // backup indicator follows the set and reset flag ops
    always @(posedge sys_clk) begin
        if (!nrst) begin
            backup_q <= 1'b0;
        end else if (set_flag_op && is_backup_op(flag_operand)) begin
            backup_q <= 1'b1;
        end else if (reset_flag_op && is_backup_op(flag_operand)) begin
            backup_q <= 1'b0;
        end
    end

    // enables are rewritten whole by each instruction
    always @(posedge sys_clk) begin
        if (!nrst) begin
            gate_en_q <= 2'h0;
        end else if (gate_wake_instruction) begin
            gate_en_q <= gate_wake_operand;
        end
    end

    // port enables: bit 0 port c, bit 1 port d
    always @(posedge sys_clk) begin
        if (!nrst) begin
            port_en_q <= 2'h0;
        end else if (port_wake_instruction) begin
            port_en_q <= port_wake_operand;
        end
    end

    // a pulse ending in the reissue cycle still sets the flag
    always @(posedge sys_clk) begin
        if (!nrst) begin
            gate11_q <= 1'b0;
        end else if (gate_en_q[`GW_FIRST] && gate_by_first_pin &&
                     gate11_end) begin
            gate11_q <= 1'b1;
        end else if (gate_wake_instruction) begin
            gate11_q <= 1'b0;
        end
    end

    // same for the second counter pin
    always @(posedge sys_clk) begin
        if (!nrst) begin
            gate12_q <= 1'b0;
        end else if (gate_en_q[`GW_SECOND] && gate_by_second_pin &&
                     gate12_end) begin
            gate12_q <= 1'b1;
        end else if (gate_wake_instruction) begin
            gate12_q <= 1'b0;
        end
    end

    // port flags: a change in the reissue cycle still sets
    always @(posedge sys_clk) begin
        if (!nrst) begin
            pd_q <= 1'b0;
        end else if (port_en_q[`PW_PORT_D] && pd_change) begin
            pd_q <= 1'b1;
        end else if (port_wake_instruction) begin
            pd_q <= 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (!nrst) begin
            pc_q <= 1'b0;
        end else if (port_en_q[`PW_PORT_C] && pc_change) begin
            pc_q <= 1'b1;
        end else if (port_wake_instruction) begin
            pc_q <= 1'b0;
        end
    end

    // request bits: timer, interrupt pin, prescaler
    assign hr_evt = {prescaler_overflow, int_edge, first_timer_underflow};
    assign hr_clr = request_clear_op ? request_clear_mask : 3'h0;

    // halt release enables
    always @(posedge sys_clk) begin
        if (!nrst) begin
            hr_en_q <= 3'h0;
        end else if (enable_set_op) begin
            hr_en_q <= enable_set_value;
        end
    end

    // set wins, so an event racing a clear is not lost
    always @(posedge sys_clk) begin
        if (!nrst) begin
            hr_req_q <= 3'h0;
        end else begin
            hr_req_q <= (hr_req_q & ~hr_clr) | hr_evt;
        end
    end

    // a wake flag mirrors request-and-enable; clear of either clears it
    genvar i;
    wire [2:0] wake_v;
    generate
        for (i = 0; i < `HR_N; i = i + 1) begin : g_wake
            wake_sticky u_wake (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .enable(hr_en_q[i]),
                .set_evt(hr_evt[i] | (hr_req_q[i] & ~hr_clr[i])),
                .clr_evt(hr_clr[i]),
                .flag_q(wake_v[i])
            );
        end
    endgenerate
    // flag order follows the request bit map
    assign w5 = wake_v[`HR_TIMER];
    assign w4 = wake_v[`HR_INT];
    assign w7 = wake_v[`HR_PRESC];

    // flags 6, 9 and 10 come from outside this block
    assign summary = w4 | w5 | wake_6_in | w7 | wake_9_in | wake_10_in;

    // every start condition flag held here blocks halt
    assign any_flag = summary | pc_q | pd_q |
                      gate11_q | gate12_q;
    // halt refused while any wake flag stands
    assign halt_grant = halt_req & ~any_flag;
    assign backup_mode = backup_q;

    // registered views for the core's move instructions
    always @(posedge sys_clk) begin
        if (!nrst) begin
            arith_and_gate_wake_status <= 4'h0;
        end else begin
            arith_and_gate_wake_status <= {carry_q, zero_q,
                                           gate12_q, gate11_q};
        end
    end

    // summary rides in the middle of the port flags
    always @(posedge sys_clk) begin
        if (!nrst) begin
            port_and_backup_wake_status <= 4'h0;
        end else begin
            port_and_backup_wake_status <= {pd_q, summary,
                                            pc_q, backup_q};
        end
    end

    // stage 15 is shown as synchronised, three cycles late
    always @(posedge sys_clk) begin
        if (!nrst) begin
            wake_status_three <= 4'h0;
        end else begin
            wake_status_three <= {w7, ph_s1, w5, w4};
        end
    end
endmodule

//--- core_model.sv
/* core model: turns an op code into a one-cycle instruction strobe.
   assumes the bench holds the operand until the strobe has gone. */
`timescale 1ns/10ps
module core_model (
    input wire sys_clk,
    input wire go,
    input wire [2:0] opc,
    output logic [6:0] stb
);
    initial stb = 7'h00;
    // one-hot, so two instructions never collide in a cycle
    always @(posedge sys_clk) begin
        stb <= go ? (7'h01 << opc) : 7'h00;
    end
endmodule

//--- halt_wake_checker_properties.sv
/* port assertions for the status flag block.
   assumes status views lag internal flags by one cycle. */
`timescale 1ns/10ps
module halt_wake_checker (
    input wire sys_clk,
    input wire nrst,
    input wire [3:0] accumulator,
    input wire alu_carry_we,
    input wire alu_carry,
    input wire load_carry_op,
    input wire set_flag_op,
    input wire reset_flag_op,
    input wire [3:0] flag_operand,
    input wire first_timer_underflow,
    input wire prescaler_overflow,
    input wire request_clear_op,
    input wire [2:0] request_clear_mask,
    input wire enable_set_op,
    input wire [2:0] enable_set_value,
    input wire [3:0] arith_and_gate_wake_status,
    input wire [3:0] port_and_backup_wake_status,
    input wire [3:0] wake_status_three,
    input wire halt_grant,
    input wire backup_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire [3:0] st1 = arith_and_gate_wake_status;
    wire [3:0] st2 = port_and_backup_wake_status;
    wire [3:0] st3 = wake_status_three;
    sequence s_sum_held;
        st2[2] ##1 st2[2];
    endsequence
    // event-free cycle after the clear, since a set would win
    sequence s_clr5;
        request_clear_op && request_clear_mask[0] && !first_timer_underflow
            ##1 !first_timer_underflow;
    endsequence
    sequence s_clr7;
        enable_set_op && !enable_set_value[2] && !prescaler_overflow
            ##1 !prescaler_overflow;
    endsequence
    property p_zero;
        (accumulator == 4'h0) [*4] |-> st1[2];
    endproperty
    property p_carry;
        alu_carry_we && !load_carry_op |-> ##2 st1[3] == $past(alu_carry, 2);
    endproperty
    property p_halt;
        s_sum_held |-> !$past(halt_grant);
    endproperty
    property p_sum;
        (st3[0] || st3[1] || st3[3]) |-> ##[0:1] st2[2];
    endproperty
    property p_bk_set;
        set_flag_op && flag_operand == 4'h2 |=> backup_mode ##1 st2[0];
    endproperty
    property p_bk_clr;
        reset_flag_op && flag_operand == 4'h2 |=> !backup_mode;
    endproperty
    property p_clr5;
        s_clr5 |=> !st3[1];
    endproperty
    property p_clr7;
        s_clr7 |=> ##1 !st3[3];
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    a_carry: assert property (p_carry) else $error("carry");
    a_halt: assert property (p_halt) else $error("halt grant");
    a_sum: assert property (p_sum) else $error("summary");
    a_bk_set: assert property (p_bk_set) else $error("bk set");
    a_bk_clr: assert property (p_bk_clr) else $error("bk clr");
    a_clr5: assert property (p_clr5) else $error("wake5 clr");
    a_clr7: assert property (p_clr7) else $error("wake7 clr");
endmodule
bind halt_wake_status_flags halt_wake_checker chk (.*);

//--- halt_wake_status_flags_test.sv
/* self-checking bench for the status flag block.
   assumes core_model issues instructions; pins driven here. */
`timescale 1ns/10ps
module halt_wake_status_flags_test;
    logic sys_clk = 1'h0, nrst = 1'h0, go = 1'h0, alu_carry = 1'h1;
    logic [2:0] opc = 3'h0, ev = 3'h0;
    logic [3:0] opd = 4'h0, accumulator = 4'h5, port_c = 4'h0, port_d = 4'h0;
    logic gate_by_first_pin = 1'h0, gate_by_second_pin = 1'h0;
    logic first_counter_input_pin = 1'h0, second_counter_input_pin = 1'h0;
    logic int_pin = 1'h0, int_rising = 1'h1, prescaler_stage_15 = 1'h0;
    logic halt_req = 1'h1, wake_6_in = 1'h0, wake_9_in = 1'h0;
    logic wake_10_in = 1'h0;
    logic [6:0] stb;
    wire gate_wake_instruction, port_wake_instruction, set_flag_op;
    wire reset_flag_op, request_clear_op, enable_set_op, load_carry_op;
    wire alu_carry_we = ev[0], first_timer_underflow = ev[1];
    wire prescaler_overflow = ev[2];
    wire [1:0] gate_wake_operand = opd[1:0], port_wake_operand = opd[1:0];
    wire [2:0] request_clear_mask = opd[2:0], enable_set_value = opd[2:0];
    wire [3:0] flag_operand = opd, load_carry_data = opd;
    wire [3:0] arith_and_gate_wake_status, port_and_backup_wake_status;
    wire [3:0] wake_status_three;
    wire halt_grant, backup_mode;
    wire [3:0] s1 = arith_and_gate_wake_status;
    wire [3:0] s2 = port_and_backup_wake_status;
    wire [3:0] s3 = wake_status_three;
    wire [3:0] hg = {3'h0, halt_grant};
    int err_count = 0, checks_done = 0;
    assign {load_carry_op, enable_set_op, request_clear_op, reset_flag_op,
        set_flag_op, port_wake_instruction, gate_wake_instruction} = stb;
    core_model core (.*);
    halt_wake_status_flags dut (.*);
    task automatic chk(string what, logic [3:0] seen, logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // operand held until the next op, past the strobe's edge
    task automatic op(logic [2:0] c, logic [3:0] d);
        @(posedge sys_clk);
        opc <= c;
        opd <= d;
        go <= 1'h1;
        @(posedge sys_clk);
        go <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic pulse(int i);
        @(posedge sys_clk);
        ev <= 3'h1 << i;
        @(posedge sys_clk);
        ev <= 3'h0;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic t_arith;
        pulse(0);
        tick(3);
        chk("carry", s1, 4'h8);
        op(6, 4'h0);
        accumulator <= 4'h0;
        tick(4);
        chk("zero", s1, 4'h4);
        op(2, 4'h2);
        tick(2);
        chk("bk set", s2, 4'h1);
        op(3, 4'h2);
        tick(2);
        chk("bk clr", s2, 4'h0);
        $display("arith end");
    endtask
    task automatic t_wake;
        op(5, 4'h7);
        int_pin <= 1'h1;
        prescaler_stage_15 <= 1'h1;
        pulse(1);
        pulse(2);
        tick(6);
        chk("st3", s3, 4'hF);
        chk("sum", s2, 4'h4);
        chk("grant", hg, 4'h0);
        op(4, 4'h1);
        tick(2);
        chk("clr1", s3, 4'hD);
        op(4, 4'h2);
        tick(2);
        chk("clr2", s3, 4'hC);
        op(5, 4'h3);
        tick(3);
        chk("en3", s3, 4'h4);
        chk("grant", hg, 4'h1);
        @(posedge sys_clk);
        wake_9_in <= 1'h1;
        tick(2);
        chk("sum9", s2, 4'h4);
        chk("grant9", hg, 4'h0);
        @(posedge sys_clk);
        wake_9_in <= 1'h0;
        int_rising <= 1'h0;
        int_pin <= 1'h0;
        tick(6);
        chk("fall", s3, 4'h5);
        op(4, 4'h2);
        tick(2);
        chk("fall clr", s3, 4'h4);
        $display("wake end");
    endtask
    task automatic t_gate;
        op(0, 4'h3);
        {gate_by_first_pin, gate_by_second_pin} <= 2'h3;
        {first_counter_input_pin, second_counter_input_pin} <= 2'h3;
        repeat (4) @(posedge sys_clk);
        first_counter_input_pin <= 1'h0;
        tick(6);
        chk("gate11", s1, 4'h5);
        @(posedge sys_clk);
        second_counter_input_pin <= 1'h0;
        tick(6);
        chk("gate12", s1, 4'h7);
        chk("grant", hg, 4'h0);
        op(0, 4'h3);
        tick(2);
        chk("gate clr", s1, 4'h4);
        op(1, 4'h3);
        port_c <= 4'h1;
        tick(6);
        chk("portc", s2, 4'h2);
        @(posedge sys_clk);
        port_d <= 4'h8;
        tick(6);
        chk("portd", s2, 4'hA);
        op(1, 4'h3);
        tick(2);
        chk("port clr", s2, 4'h0);
        $display("gate end");
    endtask
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'h1;
        tick(3);
        chk("rst st3", s3, 4'h0);
        chk("rst st2", s2, 4'h0);
        t_arith;
        t_wake;
        t_gate;
        wrap_up;
    end
    // cuts a hang short
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        wrap_up;
    end
endmodule
